/* design/emergency_power_evacuation_ctrl.sv */
// Emergency power and manual/automatic evacuation sequencer
`include "evac_params.svh"
module emergency_power_evacuation_ctrl
   import evac_pkg::*;
#(
   parameter int TICK_CYCLES = `TICK_CYCLES
) (
   // Clock and reset
   input wire logic clock,
   input wire logic reset,
   // Asynchronous inputs
   input wire pin_in_s pins,
   // Predecessor arrival seen on the field bus
   input wire logic peer_arrived_bus,
   // Configuration
   input wire ep_cfg_s ep_cfg,
   input wire evac_cfg_s evac_cfg,
   // Car state
   input wire car_state_s car,
   // Drive and monitoring
   output drive_cmd_s drive_cmd,
   output logic rot_mon_off,
   // Emergency power status
   output logic travel_ep,
   output logic arrived_ep,
   output logic arrived_doors_open,
   output logic stays_op_ack,
   // Doors
   output logic [`DOOR_W-1:0] door_open,
   output logic door_close,
   // Evacuation
   output logic evac_ack,
   output logic man_brake_en,
   output logic auto_brake_rel,
   // Logbook
   output logic log_valid,
   output log_code_e log_code
);
   typedef enum logic [3:0] {
      EP_IDLE, EP_STOP, EP_WAIT, EP_DELAY, EP_TRIP, EP_ARRIVED,
      EP_NEXT, EP_SERVICE, EP_BATT, EP_HOLD
   } ep_state_e;
   typedef enum logic [2:0] {
      EV_IDLE, EV_MAN, EV_MAN_HOLD, EV_AUTO_DLY, EV_AUTO_RUN, EV_AUTO_DONE
   } ev_state_e;

   localparam logic [`TIMER_W-1:0] MAN_HOLD = `TIMER_W'(`MAN_HOLD_TICKS);
   localparam logic [`SPEED_W-1:0] VHYST = `SPEED_W'(`VHYST_MM_S);
   localparam logic [`PRESCALE_W-1:0] TICK_LAST =
      `PRESCALE_W'(TICK_CYCLES - 1);

   pin_in_s sync1_reg, sync2_reg, sync3_reg, filt_reg;
   logic [`PRESCALE_W-1:0] pre_reg;
   logic tick;
   logic [`TIMER_W-1:0] acc_reg, ep_tmr_reg, ev_tmr_reg;
   logic auto_ok;
   ep_state_e ep_reg, ep_next;
   ev_state_e ev_reg, ev_next;
   logic ep_active, pred_arrived, over_vmax, below_hyst;
   logic os_reg, zone_prev_reg;
   logic [`DOOR_W-1:0] ev_doors;
   log_code_e log_next;
   logic [`SPEED_W-1:0] vlow;
   drive_cmd_s cmd_next;

   always_ff @(posedge clock) begin
      if (reset) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
         sync3_reg <= '0;
      end else begin
         sync1_reg <= pins;
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
      end
   end

   generate
      for (genvar i = 0; i < $bits(pin_in_s); i++) begin : g_filt
         always_ff @(posedge clock) begin
            if (reset) begin
               filt_reg[i] <= 1'b0;
            end else if (sync2_reg[i] == sync3_reg[i]) begin
               filt_reg[i] <= sync3_reg[i];
            end
         end
      end
   endgenerate

   assign tick = (pre_reg == TICK_LAST);
   always_ff @(posedge clock) begin
      if (reset || tick) begin
         pre_reg <= '0;
      end else begin
         pre_reg <= pre_reg + `PRESCALE_W'(1);
      end
   end

   always_ff @(posedge clock) begin
      if (reset || !filt_reg.auto_evac) begin
         acc_reg <= '0;
      end else if (tick && !auto_ok) begin
         acc_reg <= acc_reg + `TIMER_W'(1);
      end
   end
   assign auto_ok = filt_reg.auto_evac && (acc_reg >= evac_cfg.accept_time);

   assign over_vmax = car.speed > evac_cfg.vmax;
   assign vlow = (evac_cfg.vmax > VHYST) ? evac_cfg.vmax - VHYST : '0;
   assign below_hyst = car.speed < vlow;
   always_ff @(posedge clock) begin
      if (reset) begin
         os_reg <= 1'b0;
      end else if (over_vmax) begin
         os_reg <= 1'b1;
      end else if (below_hyst) begin
         os_reg <= 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         zone_prev_reg <= 1'b0;
      end else begin
         zone_prev_reg <= car.level_zone;
      end
   end

   assign ep_active = ep_cfg.usage_en && filt_reg.activate;
   assign pred_arrived = ep_cfg.seq_via_bus ? peer_arrived_bus
                                            : filt_reg.enable_evac;

   always_comb begin
      ep_next = ep_reg;
      log_next = LOG_NONE;
      case (ep_reg)
         EP_IDLE: begin
            if (ep_active) begin
               log_next = LOG_EP_ACTIVATED;
               if (filt_reg.battery) begin
                  ep_next = EP_BATT;
               end else if (filt_reg.stay_service) begin
                  ep_next = EP_SERVICE;
               end else begin
                  ep_next = EP_STOP;
               end
            end
         end
         EP_STOP: begin
            if (car.stopped) begin
               ep_next = EP_WAIT;
            end
         end
         EP_WAIT: begin
            if (filt_reg.stay_service) begin
               ep_next = EP_SERVICE;
            end else if (!ep_cfg.floor_valid) begin
               if (!car.door_zone) begin
                  ep_next = EP_NEXT;
               end
            end else if (pred_arrived ||
                         ep_tmr_reg >= ep_cfg.seq_timeout) begin
               ep_next = EP_DELAY;
            end
         end
         EP_DELAY: begin
            if (ep_tmr_reg >= ep_cfg.evac_delay) begin
               ep_next = EP_TRIP;
               log_next = LOG_EP_TRIP;
            end
         end
         EP_TRIP: begin
            if (car.at_ep_floor && car.stopped) begin
               ep_next = EP_ARRIVED;
            end
         end
         EP_NEXT, EP_BATT: begin
            if (car.level_zone && car.stopped) begin
               ep_next = EP_HOLD;
            end
         end
         EP_SERVICE: begin
            if (!filt_reg.stay_service) begin
               ep_next = EP_STOP;
            end
         end
         default: begin
            ep_next = ep_reg;
         end
      endcase
      if (ep_reg != EP_IDLE && !ep_active) begin
         ep_next = EP_IDLE;
         log_next = LOG_EP_DEACTIVATED;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         ep_reg <= EP_IDLE;
      end else begin
         ep_reg <= ep_next;
      end
   end

   always_ff @(posedge clock) begin
      if (reset || ep_next != ep_reg) begin
         ep_tmr_reg <= '0;
      end else if (tick && ep_tmr_reg != '1) begin
         ep_tmr_reg <= ep_tmr_reg + `TIMER_W'(1);
      end
   end

   always_comb begin
      ev_next = ev_reg;
      case (ev_reg)
         EV_IDLE: begin
            if (filt_reg.man_evac) begin
               ev_next = EV_MAN;
            end else if (auto_ok) begin
               ev_next = EV_AUTO_DLY;
            end
         end
         EV_MAN: begin
            if (car.level_zone && !zone_prev_reg) begin
               ev_next = EV_MAN_HOLD;
            end
         end
         EV_MAN_HOLD: begin
            if (ev_tmr_reg >= MAN_HOLD) begin
               ev_next = EV_MAN;
            end
         end
         EV_AUTO_DLY: begin
            if (ev_tmr_reg >= evac_cfg.delay) begin
               ev_next = EV_AUTO_RUN;
            end
         end
         EV_AUTO_RUN: begin
            if (ev_tmr_reg >= evac_cfg.duration || car.door_zone) begin
               ev_next = EV_AUTO_DONE;
            end
         end
         default: begin
            ev_next = ev_reg;
         end
      endcase
      if (ev_reg == EV_MAN || ev_reg == EV_MAN_HOLD) begin
         if (!filt_reg.man_evac) begin
            ev_next = EV_IDLE;
         end
      end else if (ev_reg != EV_IDLE) begin
         if (filt_reg.man_evac) begin
            ev_next = EV_MAN;
         end else if (!filt_reg.auto_evac) begin
            ev_next = EV_IDLE;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         ev_reg <= EV_IDLE;
      end else begin
         ev_reg <= ev_next;
      end
   end

   always_ff @(posedge clock) begin
      if (reset || ev_next != ev_reg) begin
         ev_tmr_reg <= '0;
      end else if (tick && ev_tmr_reg != '1) begin
         ev_tmr_reg <= ev_tmr_reg + `TIMER_W'(1);
      end
   end

   // doors only in zone with an openable door
   always_comb begin
      ev_doors = '0;
      if ((ev_reg == EV_MAN_HOLD || ev_reg == EV_AUTO_DONE) &&
          car.door_zone && car.stopped) begin
         ev_doors = car.openable_doors;
      end
   end

   // From the next state, so commands line up with the status outputs
   always_comb begin
      cmd_next = '0;
      if (ep_next != EP_IDLE) begin
         cmd_next.speed_step = ep_cfg.speed_step;
      end
      case (ep_next)
         EP_STOP: begin
            cmd_next.stop_quick = ep_cfg.estop_on_activate;
            cmd_next.stop_flush = !ep_cfg.estop_on_activate;
         end
         EP_TRIP: begin
            cmd_next.run = 1'b1;
            cmd_next.to_ep_floor = 1'b1;
         end
         EP_NEXT: begin
            cmd_next.run = 1'b1;
            cmd_next.dir_down = ep_cfg.hydraulic;
         end
         EP_BATT: begin
            cmd_next.run = 1'b1;
            cmd_next.drive_decides = 1'b1;
            cmd_next.dir_down = filt_reg.rescue_down;
         end
         default: begin
            cmd_next.run = 1'b0;
         end
      endcase
   end

   // Outputs registered so the pins never glitch on state decode
   always_ff @(posedge clock) begin
      if (reset) begin
         drive_cmd <= '0;
         rot_mon_off <= 1'b0;
         travel_ep <= 1'b0;
         arrived_ep <= 1'b0;
         arrived_doors_open <= 1'b0;
         stays_op_ack <= 1'b0;
         door_open <= '0;
         door_close <= 1'b0;
         log_valid <= 1'b0;
         log_code <= LOG_NONE;
      end else begin
         drive_cmd <= cmd_next;
         // rotation check off in battery rescue
         rot_mon_off <= (ep_next == EP_BATT);
         travel_ep <= (ep_next == EP_TRIP);
         arrived_ep <= (ep_next == EP_ARRIVED);
         arrived_doors_open <= (ep_next == EP_ARRIVED) &&
                               !(ep_cfg.doors_close &&
                                 ep_tmr_reg >= ep_cfg.close_after);
         stays_op_ack <= (ep_next == EP_SERVICE);
         // doors at emergency floor, optional close
         if (ep_next == EP_ARRIVED && !(ep_cfg.doors_close &&
             ep_tmr_reg >= ep_cfg.close_after)) begin
            door_open <= ep_cfg.floor_doors | ev_doors;
         end else if (ep_next == EP_HOLD) begin
            door_open <= car.openable_doors | ev_doors;
         end else begin
            door_open <= ev_doors;
         end
         door_close <= (ep_next == EP_ARRIVED) && ep_cfg.doors_close &&
                       ep_tmr_reg >= ep_cfg.close_after;
         log_valid <= (log_next != LOG_NONE);
         log_code <= log_next;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         evac_ack <= 1'b0;
         man_brake_en <= 1'b0;
         auto_brake_rel <= 1'b0;
      end else begin
         evac_ack <= (ev_next != EV_IDLE);
         man_brake_en <= (ev_next == EV_MAN) && !over_vmax;
         auto_brake_rel <= (ev_next == EV_AUTO_RUN) && !os_reg &&
                           !over_vmax;
      end
   end

endmodule

/* pkg/evac_params.svh */
// Constants for the emergency power and evacuation sequencer
`ifndef EVAC_PARAMS_SVH
`define EVAC_PARAMS_SVH
`define CLOCK_PERIOD_NS 25
`define TICK_TIME_NS 1000000
`define TICK_CYCLES (`TICK_TIME_NS / `CLOCK_PERIOD_NS)
`define TICK_MS 1
`define MAN_HOLD_MS 3000
`define MAN_HOLD_TICKS (`MAN_HOLD_MS / `TICK_MS)
`define AUTO_DURATION_MS 60000
`define AUTO_DURATION_TICKS (`AUTO_DURATION_MS / `TICK_MS)
`define VMAX_MM_S 300
`define VHYST_MM_S 100
`define TIMER_W 16
`define PRESCALE_W 16
`define SPEED_W 12
`define DOOR_W 4
`define STEP_W 4
`define STEP_MIN 1
`define STEP_MAX 9
`endif

/* pkg/evac_pkg.sv */
// Types shared by the emergency power and evacuation sequencer
package evac_pkg;
   typedef enum logic [1:0] {
      LOG_NONE,
      LOG_EP_ACTIVATED,
      LOG_EP_TRIP,
      LOG_EP_DEACTIVATED
   } log_code_e;
   // Asynchronous building, battery and drive inputs
   typedef struct packed {
      logic activate;
      logic enable_evac;
      logic stay_service;
      logic battery;
      logic rescue_down;
      logic man_evac;
      logic auto_evac;
   } pin_in_s;
   typedef struct packed {
      logic usage_en;
      logic estop_on_activate;
      logic floor_valid;
      logic hydraulic;
      logic seq_via_bus;
      logic doors_close;
      logic [3:0] floor_doors;
      logic [3:0] speed_step;
      logic [15:0] evac_delay;
      logic [15:0] seq_timeout;
      logic [15:0] close_after;
   } ep_cfg_s;
   typedef struct packed {
      logic [15:0] delay;
      logic [15:0] duration;
      logic [15:0] accept_time;
      logic [11:0] vmax;
   } evac_cfg_s;
   // Car state from the position logic, same clock
   typedef struct packed {
      logic stopped;
      logic door_zone;
      logic level_zone;
      logic at_ep_floor;
      logic [3:0] openable_doors;
      logic [11:0] speed;
   } car_state_s;
   typedef struct packed {
      logic stop_flush;
      logic stop_quick;
      logic run;
      logic dir_down;
      logic drive_decides;
      logic to_ep_floor;
      logic [3:0] speed_step;
   } drive_cmd_s;
endpackage

/* sim/evac_ctrl_sva.sv */
// Port assertions for the emergency power sequencer
`include "evac_params.svh"
module evac_ctrl_sva
   import evac_pkg::*;
#(
   parameter int TICK_CYCLES = 4
) (
   // Clock and reset
   input wire logic clock,
   input wire logic reset,
   // Inputs
   input wire pin_in_s pins,
   input wire ep_cfg_s ep_cfg,
   input wire evac_cfg_s evac_cfg,
   input wire car_state_s car,
   // Outputs
   input wire drive_cmd_s drive_cmd,
   input wire logic rot_mon_off,
   input wire logic travel_ep,
   input wire logic arrived_ep,
   input wire logic evac_ack,
   input wire logic man_brake_en,
   input wire logic auto_brake_rel,
   input wire logic log_valid,
   input wire log_code_e log_code
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);
   property p_usage;
      !ep_cfg.usage_en [*8] |-> !travel_ep && !arrived_ep && !rot_mon_off;
   endproperty
   a_usage: assert property (p_usage)
      else $error("emergency action without usage");
   property p_trip;
      $rose(travel_ep) |-> log_valid && log_code == LOG_EP_TRIP;
   endproperty
   a_trip: assert property (p_trip)
      else $error("trip start not logged");
   property p_step;
      travel_ep |-> drive_cmd.speed_step == ep_cfg.speed_step;
   endproperty
   a_step: assert property (p_step)
      else $error("wrong speed step");
   property p_arrive;
      $rose(arrived_ep) |-> $past(car.at_ep_floor);
   endproperty
   a_arrive: assert property (p_arrive)
      else $error("arrival away from floor");
   property p_pulse;
      log_valid |=> !log_valid;
   endproperty
   a_pulse: assert property (p_pulse)
      else $error("log pulse too long");
   property p_rot;
      $rose(rot_mon_off) |-> drive_cmd.drive_decides && drive_cmd.run;
   endproperty
   a_rot: assert property (p_rot)
      else $error("monitor off outside rescue");
   property p_dir;
      pins.rescue_down [*8] ##0 rot_mon_off |-> drive_cmd.dir_down;
   endproperty
   a_dir: assert property (p_dir)
      else $error("rescue direction ignored");
   property p_mspd;
      car.speed > evac_cfg.vmax ##1 car.speed > evac_cfg.vmax |-> !man_brake_en;
   endproperty
   a_mspd: assert property (p_mspd)
      else $error("manual enable while overspeed");
   property p_aspd;
      car.speed > evac_cfg.vmax ##1 car.speed > evac_cfg.vmax
         |-> !auto_brake_rel;
   endproperty
   a_aspd: assert property (p_aspd)
      else $error("release while overspeed");
   property p_man;
      pins.man_evac [*8] |-> !auto_brake_rel;
   endproperty
   a_man: assert property (p_man)
      else $error("automatic release in manual mode");
   property p_ack;
      man_brake_en |-> evac_ack;
   endproperty
   a_ack: assert property (p_ack)
      else $error("brake enable without acknowledge");
endmodule
bind emergency_power_evacuation_ctrl evac_ctrl_sva #(
   .TICK_CYCLES(TICK_CYCLES)
) i_sva (
   .clock(clock), .reset(reset), .pins(pins), .ep_cfg(ep_cfg),
   .evac_cfg(evac_cfg), .car(car), .drive_cmd(drive_cmd),
   .rot_mon_off(rot_mon_off), .travel_ep(travel_ep),
   .arrived_ep(arrived_ep), .evac_ack(evac_ack),
   .man_brake_en(man_brake_en), .auto_brake_rel(auto_brake_rel),
   .log_valid(log_valid), .log_code(log_code)
);

/* sim/car_model.sv */
// Car and drive model: one position step per cycle while moving
module car_model
   import evac_pkg::*;
(
   // Clock
   input wire logic clock,
   // Commands
   input wire drive_cmd_s cmd,
   input wire logic auto_rel,
   input wire logic man_en,
   input wire logic push,
   input wire logic coast,
   input wire logic fast,
   input wire logic home,
   // Car state
   output car_state_s car
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [9:0] pos = 10'h020;
   logic go;
   // Drive halts itself in a level zone; brake paths do not
   assign go = (cmd.run && !car.level_zone) || auto_rel || (man_en && push)
      || coast;
   always @(posedge clock) begin
      if (home)
         pos <= 10'h020;
      else if (go)
         pos <= pos + 10'h001;
   end
   always_comb begin
      car.stopped = !go;
      car.door_zone = pos[5:0] < 6'h04 || pos[5:0] > 6'h3B;
      car.level_zone = pos[5:0] < 6'h02;
      car.at_ep_floor = pos[9:6] == 4'h1;
      car.openable_doors = 4'h5;
      car.speed = go ? (fast ? 12'h190 : 12'h0C8) : 12'h000;
   end
endmodule

/* sim/tb.sv */
// Self-checking bench for the emergency power sequencer
`include "evac_params.svh"
module tb
   import evac_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int TC = 4;
   logic clock = 1'b0;
   logic reset = 1'b1;
   pin_in_s pins = '0;
   logic peer_arrived_bus = 1'b0;
   ep_cfg_s ep_cfg;
   evac_cfg_s evac_cfg;
   car_state_s car;
   drive_cmd_s drive_cmd;
   logic rot_mon_off, travel_ep, arrived_ep, arrived_doors_open, stays_op_ack;
   logic [`DOOR_W-1:0] door_open;
   logic door_close, evac_ack, man_brake_en, auto_brake_rel, log_valid;
   log_code_e log_code;
   logic coast = 1'b0, fast = 1'b0, push = 1'b0, home = 1'b0;
   int n_fail = 0, checked = 0, cyc = 0, n;
   always #12.5 clock = ~clock;
   emergency_power_evacuation_ctrl #(.TICK_CYCLES(TC)) i_dut (
      .clock(clock), .reset(reset), .pins(pins),
      .peer_arrived_bus(peer_arrived_bus), .ep_cfg(ep_cfg),
      .evac_cfg(evac_cfg), .car(car), .drive_cmd(drive_cmd),
      .rot_mon_off(rot_mon_off), .travel_ep(travel_ep),
      .arrived_ep(arrived_ep), .arrived_doors_open(arrived_doors_open),
      .stays_op_ack(stays_op_ack), .door_open(door_open),
      .door_close(door_close), .evac_ack(evac_ack),
      .man_brake_en(man_brake_en), .auto_brake_rel(auto_brake_rel),
      .log_valid(log_valid), .log_code(log_code)
   );
   car_model i_car (
      .clock(clock), .cmd(drive_cmd), .auto_rel(auto_brake_rel),
      .man_en(man_brake_en), .push(push), .coast(coast), .fast(fast),
      .home(home), .car(car)
   );
   task chk(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("FAIL at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task test_done();
      $display("Comparisons %0d, mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task tick(input int c);
      repeat (c) @(negedge clock);
   endtask
   // Counts cycles until the level shows; the cycle ceiling catches hangs
   task automatic await_lvl(ref logic s, input logic v);
      n = 0;
      while (s !== v) begin
         tick(1);
         n++;
      end
   endtask
   task relocate(input string name);
      $display("Test %s finished", name);
      pins = '0;
      coast = 1'b0;
      fast = 1'b0;
      push = 1'b0;
      home = 1'b1;
      tick(1);
      home = 1'b0;
      tick(20);
   endtask
   always @(posedge clock) begin
      cyc++;
      if (cyc == 80000) begin
         n_fail++;
         test_done();
      end
   end
   initial begin
      ep_cfg = '0;
      ep_cfg.usage_en = 1'b1;
      ep_cfg.floor_valid = 1'b1;
      ep_cfg.doors_close = 1'b1;
      ep_cfg.floor_doors = 4'h6;
      ep_cfg.speed_step = 4'h9;
      ep_cfg.evac_delay = 16'h0005;
      ep_cfg.seq_timeout = 16'h03E8;
      ep_cfg.close_after = 16'h0005;
      evac_cfg = '{16'h0005, 16'h00C8, 16'h0005, 12'h12C};
      tick(20);
      reset = 1'b0;
      tick(4);
      chk({evac_ack, man_brake_en, auto_brake_rel, travel_ep}, 16'h0000);
      coast = 1'b1;
      pins.activate = 1'b1;
      await_lvl(log_valid, 1'b1);
      chk(log_code, LOG_EP_ACTIVATED);
      chk(drive_cmd.stop_flush, 1'b1);
      chk(drive_cmd.speed_step, 4'h9);
      coast = 1'b0;
      pins.enable_evac = 1'b1;
      await_lvl(travel_ep, 1'b1);
      chk(n >= 5 * TC, 1'b1);
      chk({log_valid, log_code}, {1'b1, LOG_EP_TRIP});
      chk({drive_cmd.run, drive_cmd.to_ep_floor}, 2'h3);
      await_lvl(arrived_ep, 1'b1);
      tick(2);
      chk({arrived_doors_open, door_open}, 5'h16);
      await_lvl(door_close, 1'b1);
      chk(n >= 4 * TC, 1'b1);
      chk({door_close, arrived_doors_open, door_open}, 6'h20);
      pins = '0;
      await_lvl(log_valid, 1'b1);
      chk(log_code, LOG_EP_DEACTIVATED);
      tick(1);
      chk({travel_ep, arrived_ep}, 2'h0);
      relocate("trip");
      ep_cfg.estop_on_activate = 1'b1;
      ep_cfg.seq_via_bus = 1'b1;
      peer_arrived_bus = 1'b1;
      coast = 1'b1;
      pins.activate = 1'b1;
      await_lvl(log_valid, 1'b1);
      chk(drive_cmd.stop_quick, 1'b1);
      coast = 1'b0;
      await_lvl(travel_ep, 1'b1);
      chk(n < 40 * TC, 1'b1);
      relocate("bus");
      ep_cfg.estop_on_activate = 1'b0;
      ep_cfg.seq_via_bus = 1'b0;
      ep_cfg.seq_timeout = 16'h000A;
      pins.activate = 1'b1;
      await_lvl(travel_ep, 1'b1);
      chk(n >= 15 * TC, 1'b1);
      relocate("timeout");
      ep_cfg.floor_valid = 1'b0;
      ep_cfg.hydraulic = 1'b1;
      pins.activate = 1'b1;
      tick(20);
      chk({drive_cmd.run, drive_cmd.dir_down, travel_ep}, 3'h6);
      tick(40);
      chk({drive_cmd.run, door_open}, 5'h05);
      relocate("no floor");
      ep_cfg.usage_en = 1'b0;
      pins = 7'h60;
      tick(200);
      chk({travel_ep, drive_cmd.stop_flush, log_valid}, 3'h0);
      relocate("usage");
      ep_cfg.usage_en = 1'b1;
      pins = 7'h70;
      tick(200);
      chk({stays_op_ack, travel_ep}, 2'h2);
      relocate("service");
      for (int d = 0; d < 2; d++) begin
         pins = {4'h9, d[0], 2'h0};
         await_lvl(rot_mon_off, 1'b1);
         chk({drive_cmd.run, drive_cmd.drive_decides}, 2'h3);
         chk(drive_cmd.dir_down, d[0]);
         await_lvl(rot_mon_off, 1'b0);
         tick(2);
         chk(door_open, 4'h5);
         relocate("battery");
      end
      pins.man_evac = 1'b1;
      await_lvl(evac_ack, 1'b1);
      chk(man_brake_en, 1'b1);
      coast = 1'b1;
      fast = 1'b1;
      tick(6);
      chk(man_brake_en, 1'b0);
      coast = 1'b0;
      fast = 1'b0;
      tick(8);
      chk(man_brake_en, 1'b1);
      push = 1'b1;
      await_lvl(man_brake_en, 1'b0);
      push = 1'b0;
      tick(40);
      chk(door_open, 4'h5);
      await_lvl(man_brake_en, 1'b1);
      // Hold starts at any tick phase: 2999..3000 whole ticks plus output
      chk(n + 40 >= 2999 * TC + 2 && n + 40 <= 3000 * TC + 1, 1'b1);
      relocate("manual");
      pins.auto_evac = 1'b1;
      tick(3 * TC);
      pins.auto_evac = 1'b0;
      tick(40);
      chk(evac_ack, 1'b0);
      pins.auto_evac = 1'b1;
      await_lvl(evac_ack, 1'b1);
      chk(n >= 5 * TC, 1'b1);
      await_lvl(auto_brake_rel, 1'b1);
      chk(n >= 5 * TC, 1'b1);
      coast = 1'b1;
      fast = 1'b1;
      tick(4);
      chk(auto_brake_rel, 1'b0);
      // Speed at the hysteresis edge keeps the cut
      fast = 1'b0;
      tick(4);
      chk(auto_brake_rel, 1'b0);
      coast = 1'b0;
      tick(8);
      chk(auto_brake_rel, 1'b1);
      await_lvl(auto_brake_rel, 1'b0);
      tick(30);
      chk({auto_brake_rel, door_open}, 5'h05);
      relocate("automatic");
      pins = 7'h03;
      tick(60);
      chk({evac_ack, man_brake_en, auto_brake_rel}, 3'h6);
      relocate("priority");
      test_done();
   end
endmodule
